// >>> hdl/reset_source_controller.sv
`default_nettype none

module reset_source_controller #(
  parameter int POR_CYCLES     = reset_source_pkg::POR_CYCLES,
  parameter int MISSING_CYCLES = reset_source_pkg::MISSING_CYCLES
) (
  // Clock and power-on reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Reset pin, open drain, and analog supply monitor.
  input  wire logic        reset_pin_in_n,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  input  wire logic        supply_above,
  // Monitored system clock.
  input  wire logic        sys_clk_mon,
  // Core side.
  output logic             core_reset,
  output logic             ram_write_block,
  output logic             reset_exit,
  output logic      [15:0] fetch_addr,
  output logic             port_force,
  output logic      [7:0]  port_latch_value,
  output logic             weak_pullup_en,
  output logic             watchdog_enable,
  output logic             watchdog_tick
);

  // Counter widths are sized from the counts so that the terminal
  // values fit exactly; the casts make every truncation deliberate.
  // The power-on delay compares against its last value, so the state
  // machine leaves on the same edge on which the final count is seen.
  localparam int POR_W  = $clog2(POR_CYCLES + 1);
  localparam int MISS_W = $clog2(MISSING_CYCLES + 1);
  localparam int WDG_W  = $clog2(reset_source_pkg::WATCHDOG_DIVIDE);
  localparam logic [POR_W-1:0]  POR_LAST  = POR_W'(POR_CYCLES - 1);
  localparam logic [MISS_W-1:0] MISS_MAX  = MISS_W'(MISSING_CYCLES);
  localparam logic [WDG_W-1:0]  WDG_LAST  =
    WDG_W'(reset_source_pkg::WATCHDOG_DIVIDE - 1);

  // Sequencer state and its combinational successor.
  reset_source_pkg::reset_state_t state;
  reset_source_pkg::reset_state_t next_state;

  logic [2:0]        sync_meta;
  logic [2:0]        sync_q;
  logic              mon_clk_prev;
  logic [2:0]        drive_hist;
  logic [POR_W-1:0]  por_count;
  logic [MISS_W-1:0] miss_count;
  logic [WDG_W-1:0]  wdg_count;
  logic              mon_enable;
  logic              mon_select;
  logic              miss_enable;
  logic              power_on_flag;
  logic              pin_reset_flag;
  logic              missing_clock_flag;
  logic              cause_por;
  logic              cause_pin;
  logic              cause_supply;
  logic              cause_miss;

  // Asynchronous pins pass two flip-flops; only the second stage is read.
  // Bit 0 carries the reset pin, bit 1 the supply monitor and bit 2 the
  // monitored clock. Two stages add two cycles to every source latency,
  // which the timeout and the echo blanking below both allow for.
  // A limitation: a monitored clock faster than half of ref_clk aliases
  // in the sampler and may look stopped to the one-shot.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_meta    <= 3'b000;
      sync_q       <= 3'b000;
      mon_clk_prev <= 1'b0;
    end
    else
    begin
      sync_meta    <= {sys_clk_mon, supply_above, reset_pin_in_n};
      sync_q       <= sync_meta;
      mon_clk_prev <= sync_q[2];
    end
  end

  // Source decode. The pin is ignored while we drive it and for three
  // cycles after, since our own low level would come back through the
  // synchroniser and read as an external reset.
  // The supply source needs both the enable and the select bit, so a
  // monitor that is switched off can never hold the core in reset.
  // The missing-clock source only counts while its enable is set; the
  // one-shot itself keeps running so re-enabling sees the true age.
  wire pin_seen_low = ~sync_q[0];
  wire supply_good  = sync_q[1];
  wire mon_clk_edge = sync_q[2] ^ mon_clk_prev;
  wire pin_src      = pin_seen_low & ~reset_pin_oe & ~|drive_hist; // [R16]
  wire supply_src   = ~supply_good & mon_enable & mon_select; // [R11] [R12]
  wire miss_timeout = (miss_count == MISS_MAX);
  wire miss_src     = miss_timeout & miss_enable; // [R17]
  wire any_src      = pin_src | supply_src | miss_src; // [R21]
  wire in_reset     = (state != reset_source_pkg::ST_RUN);
  wire leaving      = in_reset & (next_state == reset_source_pkg::ST_RUN);
  wire entering     = ~in_reset & any_src;

  // Register decode. Writes are accepted in every state, including
  // while the core is held, so enables set during a reset survive its
  // exit; unmapped addresses select nothing and read as zero.
  wire sel_ctrl  = (addr == reset_source_pkg::ADDR_SUPPLY_CTRL);
  wire sel_cause = (addr == reset_source_pkg::ADDR_RESET_CAUSE);
  wire wr_ctrl   = wr & sel_ctrl;
  wire wr_cause  = wr & sel_cause;

  // Read views; unused bits read as zero.
  // The status bit is the synchronised level, two cycles behind the pin.
  wire [7:0] ctrl_view  = {mon_enable, supply_good, 6'b00_0000}; // [R14] [R15]
  wire [7:0] cause_view = {5'b0_0000, missing_clock_flag, power_on_flag,
                           pin_reset_flag}; // [R08] [R18]
  wire [7:0] read_mux   = sel_ctrl  ? ctrl_view  :
                          sel_cause ? cause_view : 8'h00;

  // Pin is pulled low only for power-on and supply causes, never for a
  // missing clock or an external pin reset.
  // The drive is released on the very edge at which the core leaves
  // reset, including the exit straight out of the power-on delay, so
  // the pin is never held low while the core already runs. A supply
  // fault seen on entry starts the drive on the entry edge itself.
  wire next_pin_drive = (in_reset & ~leaving &
                         (cause_por | cause_supply)) |
                        (entering & supply_src); // [R04] [R10] [R20]

  // Reset sequencing. Supply and pin resets leave as soon as every
  // source is gone; only the power-up path runs the release delay.
  // A supply drop during the delay returns to the wait state, so the
  // full delay is always counted over one clean stretch of good supply.
  // When the delay ends while another source is still active the
  // machine parks in the hold state instead of releasing the core.
  // An illegal code falls back to the power-up wait as the safe choice.
  always_comb
  begin
    next_state = state;
    case (state)
      reset_source_pkg::ST_POWER_WAIT:
      begin
        if (supply_good)
          next_state = reset_source_pkg::ST_POR_DELAY; // [R07]
      end
      reset_source_pkg::ST_POR_DELAY:
      begin
        if (!supply_good)
          next_state = reset_source_pkg::ST_POWER_WAIT;
        else if (por_count == POR_LAST)
          next_state = any_src ? reset_source_pkg::ST_HOLD
                               : reset_source_pkg::ST_RUN; // [R07]
      end
      reset_source_pkg::ST_HOLD:
      begin
        if (!any_src)
          next_state = reset_source_pkg::ST_RUN; // [R13] [R21]
      end
      reset_source_pkg::ST_RUN:
      begin
        if (any_src)
          next_state = reset_source_pkg::ST_HOLD; // [R21]
      end
      default:
      begin
        next_state = reset_source_pkg::ST_POWER_WAIT;
      end
    endcase
  end

  // State register and power-on delay counter.
  // The counter is cleared in every other state, so a restarted delay
  // never inherits a partial count from an interrupted one.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= reset_source_pkg::ST_POWER_WAIT;
      por_count <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == reset_source_pkg::ST_POR_DELAY)
        por_count <= por_count + POR_W'(1); // [R07]
      else
        por_count <= '0;
    end
  end

  // Missing-clock one-shot: cycles since the last monitored edge,
  // saturating so a stopped clock keeps the reset asserted.
  // Saturation also means the reset lasts until the first new edge,
  // however long the clock stays stopped.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      miss_count <= '0;
    else if (mon_clk_edge)
      miss_count <= '0;
    else if (!miss_timeout)
      miss_count <= miss_count + MISS_W'(1); // [R17]
  end

  // Causes collected over one reset episode. A fresh episode starts
  // from the sources seen on entry; later sources are added to it.
  // The power-on cause is set only by rst and dropped on the first
  // entry from run, which is how later pin and missing-clock resets
  // clear the power-on flag; a supply reset sets it again.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cause_por    <= 1'b1;
      cause_pin    <= 1'b0;
      cause_supply <= 1'b0;
      cause_miss   <= 1'b0;
    end
    else if (entering)
    begin
      cause_por    <= 1'b0;
      cause_pin    <= pin_src;
      cause_supply <= supply_src;
      cause_miss   <= miss_src;
    end
    else if (in_reset)
    begin
      cause_pin    <= cause_pin | pin_src;
      cause_supply <= cause_supply | supply_src;
      cause_miss   <= cause_miss | miss_src;
    end
  end

  // Source flags are written on exit only, so they name the last reset.
  // Software has no clear path, so there is no race between a clear
  // and a hardware update in the same cycle.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      power_on_flag      <= 1'b0;
      pin_reset_flag     <= 1'b0;
      missing_clock_flag <= 1'b0;
    end
    else if (leaving)
    begin
      power_on_flag      <= cause_por | cause_supply; // [R08]
      pin_reset_flag     <= cause_pin; // [R16]
      missing_clock_flag <= cause_miss; // [R18]
    end
  end

  // Monitor enable is set by power-on or a control write and survives other resets.
  // The detector enable is an ordinary default and returns on entry.
  // On entry the default wins over a write in the same cycle, since
  // the write belongs to code that the reset has just stopped.
  // The select bit shares the cause address with the power-on flag,
  // so writes there choose the source while reads return the flag.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mon_enable  <= 1'b1; // [R09]
      mon_select  <= 1'b1;
      miss_enable <= 1'b1;
    end
    else
    begin
      if (wr_ctrl)
        mon_enable <= wdata[reset_source_pkg::CTRL_ENABLE_BIT]; // [R14]
      if (wr_cause)
        mon_select <= wdata[reset_source_pkg::CAUSE_POWER_BIT]; // [R11]
      if (entering)
        miss_enable <= 1'b1;
      else if (wr_cause)
        miss_enable <= wdata[reset_source_pkg::CAUSE_MISSING_BIT]; // [R19]
    end
  end

  // Read data stands in the cycle after the strobe only.
  // Returning zero otherwise keeps the shared read bus quiet.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= rd ? read_mux : 8'h00;
  end

  // Open-drain reset pin and its echo blanking history.
  // The drive value is always low; only the enable decides whether the
  // pin is pulled, and the history starts full so power-up is blanked.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reset_pin_oe  <= 1'b1; // [R04]
      reset_pin_out <= 1'b0;
      drive_hist    <= 3'b111;
    end
    else
    begin
      reset_pin_oe  <= next_pin_drive;
      reset_pin_out <= 1'b0;
      drive_hist    <= {drive_hist[1:0], reset_pin_oe};
    end
  end

  // Core controls. Data memory writes are blocked rather than cleared,
  // so contents survive; the stack pointer reloads with the other
  // defaults under core_reset.
  // These follow the next state so that they change on the same edge
  // as the state itself, one register stage from every source.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      core_reset       <= 1'b1;
      ram_write_block  <= 1'b1;
      port_force       <= 1'b1;
      port_latch_value <= reset_source_pkg::PORT_RESET_VALUE;
      weak_pullup_en   <= 1'b1;
      reset_exit       <= 1'b0;
      fetch_addr       <= reset_source_pkg::FETCH_START_ADDR;
    end
    else
    begin
      core_reset       <= (next_state != reset_source_pkg::ST_RUN); // [R01]
      ram_write_block  <= (next_state != reset_source_pkg::ST_RUN); // [R02]
      port_force       <= (next_state != reset_source_pkg::ST_RUN); // [R03]
      port_latch_value <= reset_source_pkg::PORT_RESET_VALUE; // [R03]
      weak_pullup_en   <= 1'b1; // [R03]
      reset_exit       <= leaving; // [R05]
      fetch_addr       <= reset_source_pkg::FETCH_START_ADDR; // [R05]
    end
  end

  // Watchdog defaults: enabled, with a tick every twelve clocks that
  // restarts at each reset exit.
  // Restarting keeps the first tick a full twelve clocks after exit,
  // at the cost of a long period across a reset.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_enable <= 1'b1;
      watchdog_tick   <= 1'b0;
      wdg_count       <= '0;
    end
    else if (in_reset)
    begin
      watchdog_enable <= 1'b1; // [R06]
      watchdog_tick   <= 1'b0;
      wdg_count       <= '0;
    end
    else
    begin
      watchdog_tick <= (wdg_count == WDG_LAST); // [R06]
      if (wdg_count == WDG_LAST)
        wdg_count <= '0;
      else
        wdg_count <= wdg_count + WDG_W'(1);
    end
  end

endmodule

`default_nettype wire

// >>> hdl/reset_source_pkg.sv
// Functional notes
// [R01] Reset entry halts core, loads defaults, blocks interrupts.
// [R02] Reset keeps data memory; only stack pointer reloads.
// [R03] Port latches all ones, open-drain; pullups stay on.
// [R04] Power-on and supply resets drive pin low.
// [R05] Exit clears program counter, internal clock, fetch zero.
// [R06] Exit enables watchdog clocked at clock over twelve.
// [R07] Power-up waits power-on delay after supply good.
// [R08] Power-on flag bit 1, cleared by other resets; the code sets it on supply reset exit too.
// [R09] Monitor enabled by power-on, kept across other resets.
// [R10] Supply low drives pin low, holds reset meanwhile.
// [R11] Supply reset needs monitor enabled and selected.
// [R12] Software enables monitor before selecting it as source.
// [R13] Supply reset release skips the power-on delay.
// [R14] Control bit 7 enable; bits 5..0 read zero.
// [R15] Control bit 6 shows live supply good status.
// [R16] External pin low resets; pin flag bit 0.
// [R17] Missing clock over 100 us resets when enabled.
// [R18] Missing clock flag bit 2 set only after it.
// [R19] Writing bit 2 enables or disables the detector.
// [R20] Missing clock reset leaves the reset pin alone.
// [R21] Internal reset is OR of all enabled sources.
`default_nettype none

package reset_source_pkg;

  // Register map and field positions.
  localparam logic [7:0] ADDR_RESET_CAUSE   = 8'hEF;
  localparam logic [7:0] ADDR_SUPPLY_CTRL   = 8'hFF;
  localparam int         CTRL_ENABLE_BIT    = 7;
  localparam int         CTRL_STATUS_BIT    = 6;
  localparam int         CAUSE_PIN_BIT      = 0;
  localparam int         CAUSE_POWER_BIT    = 1;
  localparam int         CAUSE_MISSING_BIT  = 2;

  // Reset values forced on the core side.
  localparam logic [7:0]  PORT_RESET_VALUE  = 8'hFF;
  localparam logic [15:0] FETCH_START_ADDR  = 16'h0000;
  localparam int          WATCHDOG_DIVIDE   = 12;

  // Timing, derived from the 10 MHz reference clock.
  localparam int CLK_PERIOD_NS      = 100;
  localparam int MISSING_TIMEOUT_NS = 100_000;
  localparam int POR_DELAY_NS       = 300_000;
  localparam int MISSING_CYCLES     = MISSING_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int POR_CYCLES         = POR_DELAY_NS / CLK_PERIOD_NS;

  // Reset controller states.
  typedef enum logic [1:0]
  {
    ST_POWER_WAIT = 2'b00,
    ST_POR_DELAY  = 2'b01,
    ST_HOLD       = 2'b10,
    ST_RUN        = 2'b11
  } reset_state_t;

endpackage

`default_nettype wire

// >>> tb/reset_far_side.sv
`default_nettype none

module reset_far_side (
  // Commands from the bench.
  input  wire logic ext_low,
  input  wire logic clk_run,
  input  wire logic supply_ok,
  // Open-drain drive from the device.
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Levels seen by the device.
  output logic      pin_n,
  output logic      supply_above,
  output var logic  sys_clk_mon
);
  timeunit 1ns;
  timeprecision 100ps;

  // The pin has a pull-up, so it reads high unless someone pulls it.
  assign pin_n = !((pin_oe && !pin_out) || ext_low);
  assign supply_above = supply_ok;

  // Free system clock at an unrelated rate; it freezes on command.
  initial
  begin
    sys_clk_mon = 1'b0;
    forever
    begin
      #170;
      if (clk_run)
        sys_clk_mon = !sys_clk_mon;
    end
  end
endmodule

`default_nettype wire

// >>> tb/reset_source_controller_props.sv
`default_nettype none

module reset_source_props #(
  parameter int POR_CYCLES     = 20,
  parameter int MISSING_CYCLES = 10
) (
  // Clock, reset and register port.
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // Pin and supply monitor.
  input wire logic        reset_pin_in_n,
  input wire logic        reset_pin_oe,
  input wire logic        supply_above,
  // Core side.
  input wire logic        core_reset,
  input wire logic        ram_write_block,
  input wire logic        reset_exit,
  input wire logic [15:0] fetch_addr,
  input wire logic        port_force,
  input wire logic [7:0]  port_latch_value,
  input wire logic        weak_pullup_en,
  input wire logic        watchdog_enable,
  input wire logic        watchdog_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Cycles since reset release; saturates once the delay has passed.
  int up;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      up <= 0;
    else if (up < POR_CYCLES)
      up <= up + 1;

  a_por_hold: assert property (up < POR_CYCLES |-> core_reset)
    else $error("core left reset before the power-on delay");
  a_oe_in_reset: assert property (reset_pin_oe |-> core_reset)
    else $error("pin driven low outside reset");
  a_exit_pulse: assert property (reset_exit |->
    !core_reset && $past(core_reset) && fetch_addr == 16'h0000)
    else $error("exit pulse without reset fall or fetch zero");
  a_core_force: assert property (port_force == core_reset &&
    ram_write_block == core_reset && port_latch_value == 8'hFF)
    else $error("core side forcing does not follow reset");
  a_always_on: assert property (weak_pullup_en && watchdog_enable)
    else $error("pullups or watchdog not enabled");
  a_tick_period: assert property (watchdog_tick ##1
    (!core_reset)[*8] ##1 (!core_reset)[*3] |=> watchdog_tick)
    else $error("watchdog tick not every twelve clocks");
  a_no_tick_rst: assert property (core_reset |-> !watchdog_tick)
    else $error("watchdog tick during reset");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  a_ctrl_unused: assert property ($past(rd) &&
    $past(addr) == 8'hFF |-> rdata[5:0] == 6'h00)
    else $error("unused control bits not zero");
  a_status_live: assert property ($stable(supply_above)[*4] ##0
    (rd && addr == 8'hFF) |=> rdata[6] == $past(supply_above))
    else $error("status bit does not show supply level");
  a_pin_reset: assert property ((!reset_pin_in_n &&
    !reset_pin_oe)[*5] |-> core_reset)
    else $error("external pin low did not reset");

  // Main scenarios.
  cover property ($rose(reset_pin_oe));
  cover property ($fell(core_reset));
  cover property (rd && addr == 8'hEF);
endmodule

bind reset_source_controller reset_source_props #(
  .POR_CYCLES(POR_CYCLES),
  .MISSING_CYCLES(MISSING_CYCLES)
) u_props (.ref_clk, .rst, .addr, .rd, .rdata, .reset_pin_in_n,
  .reset_pin_oe, .supply_above, .core_reset, .ram_write_block,
  .reset_exit, .fetch_addr, .port_force, .port_latch_value,
  .weak_pullup_en, .watchdog_enable, .watchdog_tick);

`default_nettype wire

// >>> tb/reset_source_controller_tb.sv
`default_nettype none

module reset_source_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int POR = 20;
  localparam int MISS = 10;

  logic        ref_clk = 0, rst = 1, wr = 0, rd = 0;
  logic        ext_low = 0, clk_run = 1, supply_ok = 1;
  logic        pin_n, pin_out, pin_oe, supply_above, sys_clk_mon;
  logic        core_reset;
  logic [7:0]  addr = 0, wdata = 0, rdata, v;
  logic [31:0] rnd = 32'hc1f5;
  int          n_fail = 0, check_count = 0, n, m_en;
  // Reference model: monitor enable and the expected cause of each exit.
  int          m_mon = 1;
  int          cause_q[$] = '{2, 1, 4, 2};

  function logic [7:0] model_ctrl();
    return {m_mon[0], supply_ok, 6'h00};
  endfunction

  reset_source_controller #(.POR_CYCLES(POR), .MISSING_CYCLES(MISS)) dut (
    .ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .reset_pin_in_n(pin_n), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .supply_above, .sys_clk_mon, .core_reset, .ram_write_block(),
    .reset_exit(), .fetch_addr(), .port_force(), .port_latch_value(),
    .weak_pullup_en(), .watchdog_enable(), .watchdog_tick());

  reset_far_side far (.ext_low, .clk_run, .supply_ok, .pin_out, .pin_oe,
    .pin_n, .supply_above, .sys_clk_mon);

  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles; read data is taken in the single cycle it stands.
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    if (a == 8'hFF)
      m_mon = d[7];
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Bounded wait for the core reset to reach a level; n counts cycles.
  task wait_rst(input logic lvl);
    n = 0;
    while (core_reset !== lvl && n < 300)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Clock generator.
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial
  begin
    #500000;
    n_fail++;
    close_out();
  end

  // Main sequence: power-up, pin, missing clock, supply, refusals.
  initial
  begin
    repeat (5) @(posedge ref_clk);
    chk(8'({core_reset, pin_oe}), 8'h03);
    @(posedge ref_clk);
    rst <= 1'b0;
    wait_rst(1'b0);
    chk(8'(n >= POR && n < POR + 8), 8'h01);
    rd_reg(8'hEF);
    chk(v, 8'(cause_q.pop_front()));
    rd_reg(8'hFF);
    chk(v, model_ctrl());
    rd_reg(8'h12);
    chk(v, 8'h00);
    @(posedge ref_clk);
    ext_low <= 1'b1;
    wait_rst(1'b1);
    chk(8'({n < 6, pin_oe}), 8'h02);
    @(posedge ref_clk);
    ext_low <= 1'b0;
    wait_rst(1'b0);
    rd_reg(8'hEF);
    chk(v, 8'(cause_q.pop_front()));
    @(posedge ref_clk);
    clk_run <= 1'b0;
    wait_rst(1'b1);
    chk(8'({n > 8 && n < 18, pin_oe}), 8'h02);
    @(posedge ref_clk);
    clk_run <= 1'b1;
    wait_rst(1'b0);
    rd_reg(8'hEF);
    chk(v, 8'(cause_q.pop_front()));
    wr_reg(8'hEF, 8'h02);
    @(posedge ref_clk);
    clk_run <= 1'b0;
    repeat (MISS * 3) @(posedge ref_clk);
    chk(8'(core_reset), 8'h00);
    clk_run <= 1'b1;
    // Let the restarted clock clear the saturated one-shot first.
    repeat (6) @(posedge ref_clk);
    wr_reg(8'hEF, 8'h06);
    repeat (3) @(posedge ref_clk);
    chk(8'(core_reset), 8'h00);
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    wait_rst(1'b1);
    chk(8'({n < 6, pin_oe}), 8'h03);
    rd_reg(8'hFF);
    chk(v, model_ctrl());
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    wait_rst(1'b0);
    chk(8'(n < POR / 2), 8'h01);
    rd_reg(8'hEF);
    chk(v, 8'(cause_q.pop_front()));
    // Supply drop refused: first disabled, then enabled but unselected.
    for (int i = 0; i < 2; i++)
    begin
      rnd = lfsr(rnd);
      m_en = i;
      wr_reg(8'hFF, {m_en[0], rnd[6:0]});
      wr_reg(8'hEF, {5'h00, 1'b1, !m_en[0], 1'b0});
      rd_reg(8'hFF);
      chk(v, {m_en[0], 7'h40});
      @(posedge ref_clk);
      supply_ok <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk(8'(core_reset), 8'h00);
      rd_reg(8'hFF);
      chk(v, {m_en[0], 7'h00});
      @(posedge ref_clk);
      supply_ok <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    wr_reg(8'hEF, 8'h06);
    close_out();
  end
endmodule

`default_nettype wire
